/* rtl/som_status_mux.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Gain hold output high when freeze settings active after gain locked.
// - Saturation flag sticky until gain change; low during peak reset.
// - Select 0x0D: transmit quadrature cal state per channel on 7:6, 3:2.
// - Quadrature cal completion gives one pulse of about 480 ns.
// - Select 0x0D: output 4 high while RF offset cal runs.
// - Select 0x0E: output 4 for baseband cal, pulse again in RF phase.
// - Select 0x0F: ch1 Auto_gain_fsm_state, peak resets, ch1 RF cal state.
// - Select 0x10: ch2 Auto_gain_fsm_state, strength valid flags, ch2 RF cal state.
// - Select 0x11: auxiliary converter bits 11:4 on outputs 7:0.
// - Select 0x12: filter power ready pulse of about 65 ns on output 7.
// - Converter power ready pulses on output 3 when used by AGC.
// - Selects 0x12/0x13: lock, energy lost, stronger, Auto_gain_fsm_state per channel.
// - Select 0x14: ch2 overflow flags on 7:1, output 0 zero.
// - Wanted signal flag follows threshold; manual high; low gaps slow/hybrid.
// - Fast AGC: wanted signal flag low until lock, then threshold.
// - Offset word update pulses about 30 ns per update.
// - Offset measuring high while computing, low during gain change.
// - Tracking count done pulses about 30 ns when count reached.
// - Select 0x15: ch1 tracking flags on 7:4, outputs 3:0 zero.
// - Select 0x16: ch1 lock and seven-bit gain index.
// - Select 0x17: ch2 lock and seven-bit gain index.
// - Select 0x18: ch2 tracking flags on 7:4, decimated power valid on 3.
// - Overflow flags follow their stage's overflow condition.
// - Peak reset flags high while peak detectors held in reset.
// - Decimated power valid; manual high; low pulse on AGC gain change.
module som_status_mux
  import som_pkg::*;
(
  input  logic                    clk,
  input  logic                    rst_b,
  input  logic [7:0]              output_select,
  input  som_cfg_t                cfg,
  input  som_rx_t  [NUM_RX-1:0]   rx_in,
  input  som_tx_t  [NUM_TX-1:0]   tx_in,
  input  logic                    ctl_in2_pin,
  output logic [7:0]              ctl_out
);

  typedef struct packed {
    logic [7:0] out;
    logic       in2_meta;
    logic       in2_sync;
    logic       in2_prev;
    logic       rf_prev;
  } som_top_st_t;

  som_top_st_t st_reg;
  som_top_st_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Derived per channel flags

  logic [NUM_RX-1:0] filt_rdy;
  logic [NUM_RX-1:0] adc_rdy;
  logic [NUM_RX-1:0] rf_offset_word_updated;
  logic [NUM_RX-1:0] offset_tracking_count_done;
  logic [NUM_RX-1:0] soi_gap;
  logic [NUM_RX-1:0] dec_gap;
  logic [NUM_RX-1:0] dig_sat;
  logic [NUM_RX-1:0] wanted_signal_present;
  logic [NUM_RX-1:0] rf_offset_measuring;
  logic [NUM_RX-1:0] dec_power_valid;
  logic [NUM_TX-1:0] quad_done_pulse;
  logic              in2_rise;
  logic              rf_again;
  logic              gain_hold;
  logic              manual_gain_mode;

  assign manual_gain_mode = (cfg.gain_mode == GM_MANUAL);

  // Hybrid gap starts on the synchronised control input edge
  assign in2_rise = st_reg.in2_sync & ~st_reg.in2_prev;

  // Hold only counts once a gain has locked
  assign gain_hold = cfg.freeze_bits_set &
                     (rx_in[0].gain_locked | rx_in[1].gain_locked);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RX; gi++)
    begin : g_rx
      logic soi_trig;

      // Gap trigger depends on the gain mode; fast mode uses lock instead
      assign soi_trig = (cfg.gain_mode == GM_SLOW)
                        ? rx_in[gi].gain_update_expired
                        : ((cfg.gain_mode == GM_HYBRID) ? in2_rise : 1'b0);

      som_pulse #(.LEN(FILT_RDY_CYC)) u_filt (
        .clk   (clk),
        .rst_b (rst_b),
        .trig  (rx_in[gi].filter_power_event),
        .pulse (filt_rdy[gi])
      );

      som_pulse #(.LEN(ADC_RDY_CYC)) u_adc (
        .clk   (clk),
        .rst_b (rst_b),
        .trig  (rx_in[gi].adc_power_event & cfg.adc_power_for_agc),
        .pulse (adc_rdy[gi])
      );

      som_pulse #(.LEN(OFFSET_UPD_CYC)) u_upd (
        .clk   (clk),
        .rst_b (rst_b),
        .trig  (rx_in[gi].offset_word_event),
        .pulse (rf_offset_word_updated[gi])
      );

      som_pulse #(.LEN(TRACK_CNT_CYC)) u_trk (
        .clk   (clk),
        .rst_b (rst_b),
        .trig  (rx_in[gi].offset_count_event),
        .pulse (offset_tracking_count_done[gi])
      );

      som_pulse #(.LEN(SOI_GAP_CYC)) u_soi (
        .clk   (clk),
        .rst_b (rst_b),
        .trig  (soi_trig),
        .pulse (soi_gap[gi])
      );

      som_pulse #(.LEN(DEC_GAP_CYC)) u_dec (
        .clk   (clk),
        .rst_b (rst_b),
        .trig  (rx_in[gi].gain_changed & ~manual_gain_mode),
        .pulse (dec_gap[gi])
      );

      som_sat_flag u_sat (
        .clk          (clk),
        .rst_b        (rst_b),
        .overload     (rx_in[gi].digital_overload),
        .gain_changed (rx_in[gi].gain_changed),
        .peak_reset   (rx_in[gi].peak_reset),
        .sat          (dig_sat[gi])
      );

      // Manual always present; fast waits for lock; others gap on update
      assign wanted_signal_present[gi] =
        manual_gain_mode ? 1'b1 :
        (cfg.gain_mode == GM_FAST)
          ? (rx_in[gi].gain_locked & rx_in[gi].power_above_thresh)
          : (rx_in[gi].power_above_thresh & ~soi_gap[gi]);

      // Dropped on the change itself and through the settling gap
      assign rf_offset_measuring[gi] = rx_in[gi].offset_calc_active &
                                       ~rx_in[gi].gain_changed &
                                       ~dec_gap[gi];

      assign dec_power_valid[gi] = manual_gain_mode |
        (rx_in[gi].dec_power_word_ok & ~dec_gap[gi]);
    end

    for (gi = 0; gi < NUM_TX; gi++)
    begin : g_tx
      som_pulse #(.LEN(TXQ_DONE_CYC)) u_done (
        .clk   (clk),
        .rst_b (rst_b),
        .trig  (tx_in[gi].quad_cal_finished),
        .pulse (quad_done_pulse[gi])
      );
    end
  endgenerate

  // Second baseband output pulse marks the start of the RF phase
  som_pulse #(.LEN(RF_AGAIN_CYC)) u_rf_again (
    .clk   (clk),
    .rst_b (rst_b),
    .trig  (cfg.rf_offset_cal_running & ~st_reg.rf_prev),
    .pulse (rf_again)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output selection; one register stage so pins never glitch on a switch

  always_comb
  begin
    st_next          = st_reg;
    st_next.in2_meta = ctl_in2_pin;
    st_next.in2_sync = st_reg.in2_meta;
    st_next.in2_prev = st_reg.in2_sync;
    st_next.rf_prev  = cfg.rf_offset_cal_running;
    case (output_select)
      SEL_GAIN_CTL:
        st_next.out = {rx_in[0].energy_lost, rx_in[0].peak_reset,
                       rx_in[1].energy_lost, rx_in[1].peak_reset,
                       gain_hold, dig_sat[0], dig_sat[1], 1'b0};
      SEL_TXQ_RF:
        st_next.out = {tx_in[0].quad_cal_state, quad_done_pulse[0],
                       cfg.rf_offset_cal_running,
                       tx_in[1].quad_cal_state, quad_done_pulse[1],
                       1'b0};
      SEL_BB_CAL:
        st_next.out = {3'h0,
                       cfg.baseband_offset_cal_running | rf_again,
                       4'h0};
      SEL_AGC_CH1:
        st_next.out = {rx_in[0].auto_gain_fsm_state,
                       rx_in[0].peak_reset, rx_in[1].peak_reset,
                       rx_in[0].rf_offset_cal_fsm_state, 1'b0};
      SEL_AGC_CH2:
        st_next.out = {rx_in[1].auto_gain_fsm_state,
                       rx_in[1].signal_strength_valid,
                       rx_in[0].signal_strength_valid,
                       rx_in[1].rf_offset_cal_fsm_state, 1'b0};
      SEL_AUX:
        st_next.out = cfg.aux_result[AUX_MSB:AUX_LSB];
      SEL_PWR_CH1:
        st_next.out = {filt_rdy[0], rx_in[0].gain_locked,
                       rx_in[0].energy_lost, rx_in[0].stronger_signal,
                       adc_rdy[0], rx_in[0].auto_gain_fsm_state};
      SEL_PWR_CH2:
        st_next.out = {filt_rdy[1], rx_in[1].gain_locked,
                       rx_in[1].energy_lost, rx_in[1].stronger_signal,
                       adc_rdy[1], rx_in[1].auto_gain_fsm_state};
      SEL_OVF_CH2:
        st_next.out = {tx_in[1].overflow, 1'b0};
      SEL_TRK_CH1:
        st_next.out = {wanted_signal_present[0], rf_offset_word_updated[0],
                       rf_offset_measuring[0],
                       offset_tracking_count_done[0], 4'h0};
      SEL_IDX_CH1:
        st_next.out = {rx_in[0].gain_locked, rx_in[0].gain_index};
      SEL_IDX_CH2:
        st_next.out = {rx_in[1].gain_locked, rx_in[1].gain_index};
      SEL_TRK_CH2:
        st_next.out = {wanted_signal_present[1], rf_offset_word_updated[1],
                       rf_offset_measuring[1],
                       offset_tracking_count_done[1], dec_power_valid[1],
                       1'b0, dec_power_valid[0], 1'b0};
      default:
        st_next.out = OUT_RST; // Groups outside this block read zero
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign ctl_out = st_reg.out;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  aux_bits_a: assert property (
    output_select == SEL_AUX |=>
      ctl_out == $past(cfg.aux_result[AUX_MSB:AUX_LSB]))
    else $error("aux bits not on outputs");

  ovf_zero_a: assert property (
    output_select == SEL_OVF_CH2 |=>
      ctl_out == {$past(tx_in[1].overflow), 1'b0})
    else $error("overflow group wrong");

  track_low_zero_a: assert property (
    output_select == SEL_TRK_CH1 |=> ctl_out[3:0] == 4'h0)
    else $error("tracking group low outputs not zero");

  gain_index_a: assert property (
    output_select == SEL_IDX_CH1 |=>
      ctl_out == {$past(rx_in[0].gain_locked), $past(rx_in[0].gain_index)})
    else $error("ch1 gain index group wrong");

  rf_busy_a: assert property (
    output_select == SEL_TXQ_RF |=>
      ctl_out[4] == $past(cfg.rf_offset_cal_running))
    else $error("RF cal busy not shown");

  manual_soi_a: assert property (
    (output_select == SEL_TRK_CH1 && cfg.gain_mode == GM_MANUAL) |=>
      ctl_out[7])
    else $error("wanted signal low in manual mode");

  fast_soi_a: assert property (
    (output_select == SEL_TRK_CH1 && cfg.gain_mode == GM_FAST &&
     !rx_in[0].gain_locked) |=> !ctl_out[7])
    else $error("wanted signal high before lock");

  hold_unlocked_a: assert property (
    (output_select == SEL_GAIN_CTL && !rx_in[0].gain_locked &&
     !rx_in[1].gain_locked) |=> !ctl_out[3])
    else $error("gain hold shown without lock");

  quad_done_a: assert property (
    (output_select == SEL_TXQ_RF && tx_in[0].quad_cal_finished) ##1
    (output_select == SEL_TXQ_RF) |=> ctl_out[5])
    else $error("quad cal done pulse missing");

endmodule

/* rtl/som_pkg.sv */
package som_pkg;

  // Core clock of the status logic, 125 MHz
  localparam int CLK_PERIOD_NS = 8;

  // Nominal pulse and gap lengths in nanoseconds
  localparam int TXQ_DONE_NS   = 480;
  localparam int FILT_RDY_NS   = 65;
  localparam int ADC_RDY_NS    = 30;
  localparam int OFFSET_UPD_NS = 30;
  localparam int TRACK_CNT_NS  = 30;
  localparam int SOI_GAP_NS    = 400;
  localparam int DEC_GAP_NS    = 400;
  localparam int RF_AGAIN_NS   = 30;

  // Least time in whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int r;
    r = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (r < 1) ? 1 : r;
  endfunction

  localparam int TXQ_DONE_CYC   = ns_to_cyc(TXQ_DONE_NS);
  localparam int FILT_RDY_CYC   = ns_to_cyc(FILT_RDY_NS);
  localparam int ADC_RDY_CYC    = ns_to_cyc(ADC_RDY_NS);
  localparam int OFFSET_UPD_CYC = ns_to_cyc(OFFSET_UPD_NS);
  localparam int TRACK_CNT_CYC  = ns_to_cyc(TRACK_CNT_NS);
  localparam int SOI_GAP_CYC    = ns_to_cyc(SOI_GAP_NS);
  localparam int DEC_GAP_CYC    = ns_to_cyc(DEC_GAP_NS);
  localparam int RF_AGAIN_CYC   = ns_to_cyc(RF_AGAIN_NS);

  // Channel counts and field positions
  localparam int NUM_RX  = 2;
  localparam int NUM_TX  = 2;
  localparam int AUX_MSB = 11;
  localparam int AUX_LSB = 4;

  // Select codes
  localparam logic [7:0] SEL_GAIN_CTL = 8'h0C;
  localparam logic [7:0] SEL_TXQ_RF   = 8'h0D;
  localparam logic [7:0] SEL_BB_CAL   = 8'h0E;
  localparam logic [7:0] SEL_AGC_CH1  = 8'h0F;
  localparam logic [7:0] SEL_AGC_CH2  = 8'h10;
  localparam logic [7:0] SEL_AUX      = 8'h11;
  localparam logic [7:0] SEL_PWR_CH1  = 8'h12;
  localparam logic [7:0] SEL_PWR_CH2  = 8'h13;
  localparam logic [7:0] SEL_OVF_CH2  = 8'h14;
  localparam logic [7:0] SEL_TRK_CH1  = 8'h15;
  localparam logic [7:0] SEL_IDX_CH1  = 8'h16;
  localparam logic [7:0] SEL_IDX_CH2  = 8'h17;
  localparam logic [7:0] SEL_TRK_CH2  = 8'h18;

  localparam logic [7:0] OUT_RST = 8'h00;

  typedef enum logic [1:0] {
    GM_MANUAL,
    GM_SLOW,
    GM_FAST,
    GM_HYBRID
  } som_gain_mode_t;

  // Per receive channel status from the gain and offset logic
  typedef struct packed {
    logic [2:0] auto_gain_fsm_state;
    logic       gain_locked;
    logic       energy_lost;
    logic       stronger_signal;
    logic       peak_reset;
    logic       digital_overload;
    logic       gain_changed;
    logic [6:0] gain_index;
    logic       signal_strength_valid;
    logic [1:0] rf_offset_cal_fsm_state;
    logic       filter_power_event;
    logic       adc_power_event;
    logic       power_above_thresh;
    logic       offset_word_event;
    logic       offset_count_event;
    logic       offset_calc_active;
    logic       dec_power_word_ok;
    logic       gain_update_expired;
  } som_rx_t;

  // Per transmit channel status
  typedef struct packed {
    logic [1:0] quad_cal_state;
    logic       quad_cal_finished;
    logic [6:0] overflow;
  } som_tx_t;

  // Device wide configuration and status
  typedef struct packed {
    som_gain_mode_t gain_mode;
    logic           freeze_bits_set;
    logic           adc_power_for_agc;
    logic           rf_offset_cal_running;
    logic           baseband_offset_cal_running;
    logic [11:0]    aux_result;
  } som_cfg_t;

endpackage

/* rtl/som_pulse.sv */
`timescale 1ns/1ps
// Stretches a one-cycle event into a pulse of LEN cycles
module som_pulse
  import som_pkg::*;
#(
  parameter int LEN = 4
)(
  input  logic clk,
  input  logic rst_b,
  input  logic trig,
  output logic pulse
);

  localparam int CW = $clog2(LEN + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
  } som_pulse_st_t;

  som_pulse_st_t st_reg;
  som_pulse_st_t st_next;

  // A new event restarts the pulse, so close events merge
  always_comb
  begin
    st_next = st_reg;
    if (trig)
    begin
      st_next.out = 1'b1;
      st_next.cnt = CW'(LEN - 1);
    end
    else if (st_reg.cnt != '0)
    begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    else
    begin
      st_next.out = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign pulse = st_reg.out;

  pulse_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    trig |=> pulse)
    else $error("pulse did not start after event");

  pulse_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pulse && st_reg.cnt == '0 && !trig) |=> !pulse)
    else $error("pulse outlived its length");

endmodule

/* rtl/som_sat_flag.sv */
`timescale 1ns/1ps
// Sticky digital saturation flag of one receive channel
module som_sat_flag
  import som_pkg::*;
(
  input  logic clk,
  input  logic rst_b,
  input  logic overload,
  input  logic gain_changed,
  input  logic peak_reset,
  output logic sat
);

  typedef struct packed {
    logic flag;
  } som_sat_st_t;

  som_sat_st_t st_reg;
  som_sat_st_t st_next;

  // Gain change clears; peak reset keeps it low even if overload remains
  always_comb
  begin
    st_next = st_reg;
    if (gain_changed || peak_reset)
      st_next.flag = 1'b0;
    else if (overload)
      st_next.flag = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sat = st_reg.flag;

  sat_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (gain_changed || peak_reset) |=> !sat)
    else $error("saturation flag not cleared");

  sat_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sat && !gain_changed && !peak_reset) |=> sat)
    else $error("saturation flag dropped without gain change");

endmodule

/* tb/som_host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Baseband host: picks the status group and watches the pins
module som_host_model
  import som_pkg::*;
(
  input  logic       clk,
  input  logic [7:0] ctl_out,
  output logic [7:0] output_select
);
  logic [7:0] seen_reg;

  // Select starts at the reset group so nothing random reaches the pins
  initial output_select = OUT_RST;

  // Called just after an edge, so the block samples a settled code
  task automatic pick(input logic [7:0] code);
    output_select = code;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // The host samples the pins once a cycle, as a real processor would
  always_ff @(posedge clk)
  begin
    seen_reg <= ctl_out;
  end
endmodule

/* tb/status_output_mux_bench.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module status_output_mux_bench
  import som_pkg::*;
;
  logic                  clk;
  logic                  rst_b;
  som_cfg_t              cfg;
  som_rx_t  [NUM_RX-1:0] rx_in;
  som_tx_t  [NUM_TX-1:0] tx_in;
  logic                  ctl_in2_pin;
  logic [7:0]            ctl_out;
  logic [7:0]            output_select;
  logic [7:0]            exp_q;
  logic [31:0]           r;
  int                    failures;
  int                    total_checks;

  som_status_mux u_dut (
    .clk           (clk),
    .rst_b         (rst_b),
    .output_select (output_select),
    .cfg           (cfg),
    .rx_in         (rx_in),
    .tx_in         (tx_in),
    .ctl_in2_pin   (ctl_in2_pin),
    .ctl_out       (ctl_out)
  );

  som_host_model u_host (
    .clk           (clk),
    .ctl_out       (ctl_out),
    .output_select (output_select)
  );

  // 125 MHz clock
  initial clk = 1'b0;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Every drive lands 1 ns after the edge, clear of the sampling instant
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic idle();
    cfg         = '0;
    rx_in       = '0;
    tx_in       = '0;
    ctl_in2_pin = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Expected pin values for level sources, events held quiet
  function automatic logic soi_exp(input som_rx_t x);
    if (cfg.gain_mode == GM_MANUAL)
      return 1'b1;
    if (cfg.gain_mode == GM_FAST)
      return x.gain_locked & x.power_above_thresh;
    return x.power_above_thresh;
  endfunction

  function automatic logic decv_exp(input som_rx_t x);
    return (cfg.gain_mode == GM_MANUAL) | x.dec_power_word_ok;
  endfunction

  function automatic logic [7:0] exp_static(input logic [7:0] sel);
    som_rx_t a;
    som_rx_t b;
    a = rx_in[0];
    b = rx_in[1];
    case (sel)
      SEL_GAIN_CTL: return {a.energy_lost, a.peak_reset, b.energy_lost,
        b.peak_reset, cfg.freeze_bits_set & (a.gain_locked | b.gain_locked),
        3'h0};
      SEL_TXQ_RF:   return {tx_in[0].quad_cal_state, 1'b0,
        cfg.rf_offset_cal_running, tx_in[1].quad_cal_state, 2'h0};
      SEL_BB_CAL:   return {3'h0, cfg.baseband_offset_cal_running, 4'h0};
      SEL_AGC_CH1:  return {a.auto_gain_fsm_state, a.peak_reset,
        b.peak_reset, a.rf_offset_cal_fsm_state, 1'b0};
      SEL_AGC_CH2:  return {b.auto_gain_fsm_state, b.signal_strength_valid,
        a.signal_strength_valid, b.rf_offset_cal_fsm_state, 1'b0};
      SEL_AUX:      return cfg.aux_result[AUX_MSB:AUX_LSB];
      SEL_PWR_CH1:  return {1'b0, a.gain_locked, a.energy_lost,
        a.stronger_signal, 1'b0, a.auto_gain_fsm_state};
      SEL_PWR_CH2:  return {1'b0, b.gain_locked, b.energy_lost,
        b.stronger_signal, 1'b0, b.auto_gain_fsm_state};
      SEL_OVF_CH2:  return {tx_in[1].overflow, 1'b0};
      SEL_TRK_CH1:  return {soi_exp(a), 1'b0, a.offset_calc_active, 5'h00};
      SEL_IDX_CH1:  return {a.gain_locked, a.gain_index};
      SEL_IDX_CH2:  return {b.gain_locked, b.gain_index};
      SEL_TRK_CH2:  return {soi_exp(b), 1'b0, b.offset_calc_active, 1'b0,
        decv_exp(b), 1'b0, decv_exp(a), 1'b0};
      default:      return 8'h00;
    endcase
  endfunction

  // Random levels; events and overload stay low so no stretcher runs
  task automatic rand_inputs();
    r   = $urandom;
    cfg = r[$bits(som_cfg_t)-1:0];
    cfg.rf_offset_cal_running = 1'b0;
    for (int ch = 0; ch < NUM_RX; ch++)
    begin
      r = $urandom;
      rx_in[ch] = r[$bits(som_rx_t)-1:0];
      rx_in[ch].gain_changed        = 1'b0;
      rx_in[ch].filter_power_event  = 1'b0;
      rx_in[ch].adc_power_event     = 1'b0;
      rx_in[ch].offset_word_event   = 1'b0;
      rx_in[ch].offset_count_event  = 1'b0;
      rx_in[ch].gain_update_expired = 1'b0;
      rx_in[ch].digital_overload    = 1'b0;
      r = $urandom;
      tx_in[ch] = r[$bits(som_tx_t)-1:0];
      tx_in[ch].quad_cal_finished = 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle event of the given kind; kinds 5 and 7 stay high
  task automatic fire(input int kind, input int ch);
    case (kind)
      0:       tx_in[ch].quad_cal_finished = 1'b1;
      1:       rx_in[ch].filter_power_event = 1'b1;
      2, 9:    rx_in[ch].adc_power_event = 1'b1;
      3:       rx_in[ch].offset_word_event = 1'b1;
      4:       rx_in[ch].offset_count_event = 1'b1;
      5:       cfg.rf_offset_cal_running = 1'b1;
      6:       rx_in[ch].gain_update_expired = 1'b1;
      7:       ctl_in2_pin = 1'b1;
      default: rx_in[ch].gain_changed = 1'b1;
    endcase
    step(1);
    tx_in[ch].quad_cal_finished   = 1'b0;
    rx_in[ch].filter_power_event  = 1'b0;
    rx_in[ch].adc_power_event     = 1'b0;
    rx_in[ch].offset_word_event   = 1'b0;
    rx_in[ch].offset_count_event  = 1'b0;
    rx_in[ch].gain_update_expired = 1'b0;
    rx_in[ch].gain_changed        = 1'b0;
  endtask

  // Width of the run at level lvl on pin b; zero if it never shows
  task automatic measure(input logic [7:0] sel, input int b, input logic lvl,
                         input int kind, input int ch, input int len);
    int n;
    int w;
    idle();
    case (kind)
      2:       cfg.adc_power_for_agc = 1'b1;
      6, 7:    rx_in[ch].power_above_thresh = 1'b1;
      8, 10:
      begin
        rx_in[ch].dec_power_word_ok  = 1'b1;
        rx_in[ch].offset_calc_active = 1'b1;
      end
      default: ;
    endcase
    if (kind == 6 || kind == 8)
      cfg.gain_mode = GM_SLOW;
    if (kind == 7)
      cfg.gain_mode = GM_HYBRID;
    u_host.pick(sel);
    step(4);
    fire(kind, ch);
    n = 0;
    w = 0;
    while (ctl_out[b] !== lvl && w < 12)
    begin
      step(1);
      w++;
    end
    while (ctl_out[b] === lvl && n < 250)
    begin
      step(1);
      n++;
    end
    check("pulse width", 8'(n), 8'(len));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need a few thousand cycles, this allows far more
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    failures++;
    $display("watchdog expired");
    wrap_up();
  end

  initial
  begin
    failures     = 0;
    total_checks = 0;
    rst_b        = 1'b0;
    idle();
    void'($urandom(84));
    step(16);
    check("reset pins", ctl_out, OUT_RST);
    check("host view", u_host.seen_reg, OUT_RST);
    rst_b = 1'b1;
    // Select changes every cycle, so each group follows on the next edge
    for (int i = 0; i < 1500; i++)
    begin
      step(1);
      if (i > 0)
        check("static group", ctl_out, exp_q);
      u_host.pick(8'h0B + 8'($urandom % 15));
      rand_inputs();
      exp_q = exp_static(output_select);
    end
    $display("test random groups done");

    // Saturation flag: sticky, cleared by gain change, low in peak reset
    idle();
    u_host.pick(SEL_GAIN_CTL);
    rx_in[0].digital_overload = 1'b1;
    step(3);
    check("sat set", ctl_out, 8'h04);
    rx_in[0].digital_overload = 1'b0;
    rx_in[1].digital_overload = 1'b1;
    step(3);
    check("sat sticky", ctl_out, 8'h06);
    rx_in[1].digital_overload = 1'b0;
    fire(8, 0);
    step(3);
    check("sat cleared", ctl_out, 8'h02);
    rx_in[0].digital_overload = 1'b1;
    rx_in[0].peak_reset = 1'b1;
    fire(8, 0);
    step(3);
    check("sat in peak reset", ctl_out, 8'h42);
    rx_in[0].peak_reset = 1'b0;
    step(3);
    check("sat again", ctl_out, 8'h06);
    $display("test saturation done");

    // RF offset calibration busy level on the 0x0D group
    idle();
    u_host.pick(SEL_TXQ_RF);
    cfg.rf_offset_cal_running = 1'b1;
    step(3);
    check("rf cal busy", ctl_out, 8'h10);
    cfg.rf_offset_cal_running = 1'b0;
    step(3);
    check("rf cal idle", ctl_out, 8'h00);
    $display("test rf cal done");

    // Stretched events, low gaps and refused triggers
    measure(SEL_TXQ_RF, 5, 1'b1, 0, 0, TXQ_DONE_CYC);
    measure(SEL_TXQ_RF, 1, 1'b1, 0, 1, TXQ_DONE_CYC);
    measure(SEL_BB_CAL, 4, 1'b1, 5, 0, RF_AGAIN_CYC);
    measure(SEL_PWR_CH1, 7, 1'b1, 1, 0, FILT_RDY_CYC);
    measure(SEL_PWR_CH2, 7, 1'b1, 1, 1, FILT_RDY_CYC);
    measure(SEL_PWR_CH1, 3, 1'b1, 2, 0, ADC_RDY_CYC);
    measure(SEL_PWR_CH2, 3, 1'b1, 2, 1, ADC_RDY_CYC);
    measure(SEL_PWR_CH1, 3, 1'b1, 9, 0, 0);
    measure(SEL_TRK_CH1, 6, 1'b1, 3, 0, OFFSET_UPD_CYC);
    measure(SEL_TRK_CH2, 6, 1'b1, 3, 1, OFFSET_UPD_CYC);
    measure(SEL_TRK_CH1, 4, 1'b1, 4, 0, TRACK_CNT_CYC);
    measure(SEL_TRK_CH2, 4, 1'b1, 4, 1, TRACK_CNT_CYC);
    measure(SEL_TRK_CH1, 7, 1'b0, 6, 0, SOI_GAP_CYC);
    measure(SEL_TRK_CH1, 7, 1'b0, 7, 0, SOI_GAP_CYC);
    measure(SEL_TRK_CH2, 3, 1'b0, 8, 1, DEC_GAP_CYC);
    measure(SEL_TRK_CH2, 5, 1'b0, 8, 1, DEC_GAP_CYC + 1);
    measure(SEL_TRK_CH2, 5, 1'b0, 10, 1, 1);
    $display("test pulses done");
    wrap_up();
  end
endmodule
